// [verilog/dacr_pkg.sv]
// register map, field positions, reset values and carrier types of the config bank
// assumes one 40 MHz core clock and a synchronous active-high reset
package dacr_pkg;

	localparam logic [12:0] ADDR_DEV_INDEX  = 13'h0005;
	localparam logic [12:0] ADDR_POWER_MODE = 13'h0008;
	localparam logic [12:0] ADDR_ENHANCE    = 13'h000c;
	localparam logic [12:0] ADDR_OUT_MODE   = 13'h0014;
	localparam logic [12:0] ADDR_REF_SEL    = 13'h0018;
	localparam logic [12:0] ADDR_PAT1_LO    = 13'h0019;
	localparam logic [12:0] ADDR_PAT1_HI    = 13'h001a;
	localparam logic [12:0] ADDR_PAT2_LO    = 13'h001b;
	localparam logic [12:0] ADDR_PAT2_HI    = 13'h001c;
	localparam logic [12:0] ADDR_SIG_LO     = 13'h0024;
	localparam logic [12:0] ADDR_SIG_HI     = 13'h0025;
	localparam logic [12:0] ADDR_OVR        = 13'h002a;
	localparam logic [12:0] ADDR_OUT_ASSIGN = 13'h002e;
	localparam logic [12:0] ADDR_SYNC       = 13'h003a;
	localparam logic [12:0] ADDR_TRANSFER   = 13'h00ff;
	localparam logic [12:0] ADDR_RATE       = 13'h0100;
	localparam logic [12:0] ADDR_PIN2       = 13'h0101;
	localparam logic [12:0] ADDR_PIN3       = 13'h0102;

	localparam logic [7:0] RST_DEV_INDEX  = 8'h03;
	localparam logic [7:0] RST_POWER_MODE = 8'h00;
	localparam logic [7:0] RST_ENHANCE    = 8'h00;
	localparam logic [7:0] RST_OUT_MODE   = 8'h00;
	localparam logic [7:0] RST_REF_SEL    = 8'h04;
	localparam logic [7:0] RST_PATTERN    = 8'h00;
	localparam logic [15:0] RST_SIGNATURE = 16'hffff;
	localparam logic [7:0] RST_OVR        = 8'h01;
	localparam logic [7:0] RST_SYNC       = 8'h00;
	localparam logic [7:0] RST_RATE       = 8'h00;
	localparam logic [7:0] RST_PIN        = 8'h00;

	localparam int PM_EXT_FUNC_BIT  = 5;
	localparam int CHOP_BIT         = 2;
	localparam int LOGIC_TYPE_LSB   = 6;
	localparam int REF_LSB          = 0;
	localparam int OVR_EN_BIT       = 0;
	localparam int SYNC_NEXT_BIT    = 2;
	localparam int SYNC_EN_BIT      = 1;
	localparam int TRANSFER_BIT     = 0;
	localparam int RATE_EN_BIT      = 6;
	localparam int RATE_LSB         = 0;
	localparam int OUT_DIS_EN_BIT   = 7;
	localparam int PULLDOWN_DIS_BIT = 0;
	localparam int CM_PD_BIT        = 3;

	localparam logic [1:0] PM_NORMAL     = 2'h0;
	localparam logic [1:0] PM_POWER_DOWN = 2'h1;
	localparam logic [1:0] PM_STANDBY    = 2'h2;
	localparam logic [1:0] PM_DIG_RESET  = 2'h3;

	// highest rate code the part may run at; stands for the factory grade
	localparam logic [2:0] SPEED_GRADE_CODE = 3'h5;

	localparam logic [3:0] INSTR_LAST_BIT = 4'hf;
	localparam logic [3:0] BYTE_LAST_BIT  = 4'h7;

	typedef struct packed {
		logic [7:0] dev_index;
		logic [7:0] power_mode;
		logic [7:0] enhance;
		logic [7:0] out_mode;
		logic [7:0] ref_sel;
		logic [7:0] pat1_lo;
		logic [7:0] pat1_hi;
		logic [7:0] pat2_lo;
		logic [7:0] pat2_hi;
		logic [15:0] signature;
		logic [7:0] ovr;
		logic [1:0] out_assign;
		logic [7:0] sync_ctl;
		logic [7:0] rate_staged;
		logic [7:0] rate_active;
		logic [7:0] pin2;
		logic [7:0] pin3;
	} dacr_regs_type;

	typedef struct packed {
		logic        sclk_prev;
		logic [15:0] shift;
		logic [3:0]  cnt;
		logic        data_phase;
		logic        rd;
		logic [12:0] addr;
		logic [7:0]  tx;
		logic        skip;
		logic        oe;
	} dacr_spi_type;

	typedef struct packed {
		logic [2:0]  ref_span;
		logic [15:0] pattern_one;
		logic [15:0] pattern_two;
		logic        overrange_out_en;
		logic        chan_a_source;
		logic        chan_b_source;
		logic        chop_en;
		logic [1:0]  logic_type;
		logic        datapath_clk_en;
		logic        datapath_reset;
		logic        data_out_en;
		logic        full_power_down;
		logic        standby;
		logic        divider_sync;
		logic        rate_override_en;
		logic [2:0]  rate_code;
		logic        sdio_pulldown_disable;
		logic        common_mode_generator_power_down;
	} dacr_ctl_type;

	typedef struct packed {
		dacr_regs_type regs;
		dacr_spi_type  spi;
		dacr_ctl_type  ctl;
	} dacr_state_type;

endpackage : dacr_pkg

// [verilog/dacr_config_regs.sv]
// configuration register bank behind the serial control port, with control decode
// assumes serial pins are synchronous to core_clk and sclk is well below core_clk/2
module dacr_config_regs (
	input  wire logic                  core_clk,
	input  wire logic                  reset,
	input  wire logic                  spi_sclk,
	input  wire logic                  spi_cs_n,
	input  wire logic                  sdio_in,
	output logic                       sdio_out,
	output logic                       sdio_oe,
	input  wire logic                  power_down_pin,
	input  wire logic                  output_disable_pin,
	input  wire logic                  sync_in,
	input  wire logic [15:0]           signature_result,
	output dacr_pkg::dacr_ctl_type     ctl
);
	import dacr_pkg::*;

	dacr_state_type st;
	dacr_state_type next_st;

	logic        sclk_rise;
	logic        sclk_fall;
	logic [15:0] sh;
	logic        wr_strobe;
	logic [12:0] wr_addr;
	logic [7:0]  wr_data;
	logic        sync_pass;
	logic [1:0]  eff_mode;
	logic [2:0]  pm_bits;
	logic        rate_upgrade;

	function automatic logic [7:0] reg_read(input dacr_regs_type r, input logic [12:0] a);
		logic [7:0] d;
		d = 8'h00;
		case (a)
			ADDR_DEV_INDEX:  d = r.dev_index;
			ADDR_POWER_MODE: d = r.power_mode;
			ADDR_ENHANCE:    d = r.enhance;
			ADDR_OUT_MODE:   d = r.out_mode;
			ADDR_REF_SEL:    d = r.ref_sel;
			ADDR_PAT1_LO:    d = r.pat1_lo;
			ADDR_PAT1_HI:    d = r.pat1_hi;
			ADDR_PAT2_LO:    d = r.pat2_lo;
			ADDR_PAT2_HI:    d = r.pat2_hi;
			ADDR_SIG_LO:     d = r.signature[7:0];
			ADDR_SIG_HI:     d = r.signature[15:8];
			ADDR_OVR:        d = r.ovr;
			// local register: first selected channel answers
			ADDR_OUT_ASSIGN: d = {7'h00, r.dev_index[0] ? r.out_assign[0] : r.out_assign[1]};
			ADDR_SYNC:       d = r.sync_ctl;
			ADDR_RATE:       d = r.rate_staged;
			ADDR_PIN2:       d = r.pin2;
			ADDR_PIN3:       d = r.pin3;
			default:         d = 8'h00;
		endcase
		return d;
	endfunction : reg_read

	// returns {clock enable, datapath reset, output enable}
	function automatic logic [2:0] pm_decode(input logic [1:0] mode);
		logic [2:0] b;
		b = 3'h4;
		case (mode)
			PM_NORMAL:     b = 3'h5;
			PM_POWER_DOWN: b = 3'h2;
			PM_STANDBY:    b = 3'h0;
			PM_DIG_RESET:  b = 3'h3;
			default:       b = 3'h5;
		endcase
		return b;
	endfunction : pm_decode

	assign sclk_rise = spi_sclk & ~st.spi.sclk_prev;
	assign sclk_fall = ~spi_sclk & st.spi.sclk_prev;
	assign sdio_out  = st.spi.tx[7];
	assign sdio_oe   = st.spi.oe;
	assign ctl       = st.ctl;

	always_comb begin
		next_st   = st;
		sh        = {st.spi.shift[14:0], sdio_in};
		wr_strobe = 1'b0;
		wr_addr   = st.spi.addr;
		wr_data   = sh[7:0];

		// serial port: 16-bit instruction, then bytes with falling address
		next_st.spi.sclk_prev = spi_sclk;
		if (spi_cs_n) begin
			next_st.spi.cnt        = 4'h0;
			next_st.spi.data_phase = 1'b0;
			next_st.spi.oe         = 1'b0;
			next_st.spi.skip       = 1'b0;
		end else if (sclk_rise) begin
			next_st.spi.shift = sh;
			next_st.spi.cnt   = st.spi.cnt + 4'h1;
			if (!st.spi.data_phase && st.spi.cnt == INSTR_LAST_BIT) begin
				next_st.spi.rd         = sh[15];
				next_st.spi.addr       = sh[12:0];
				next_st.spi.data_phase = 1'b1;
				next_st.spi.cnt        = 4'h0;
				next_st.spi.oe         = sh[15];
				next_st.spi.skip       = 1'b1;
				next_st.spi.tx         = reg_read(st.regs, sh[12:0]);
			end else if (st.spi.data_phase && st.spi.cnt == BYTE_LAST_BIT) begin
				next_st.spi.cnt  = 4'h0;
				next_st.spi.addr = st.spi.addr - 13'h0001;
				wr_strobe        = ~st.spi.rd;
				if (st.spi.rd) begin
					next_st.spi.tx   = reg_read(st.regs, st.spi.addr - 13'h0001);
					next_st.spi.skip = 1'b1;
				end
			end
		end else if (sclk_fall && st.spi.data_phase && st.spi.rd) begin
			// first falling edge after a load keeps the msb on the line
			if (st.spi.skip) begin
				next_st.spi.skip = 1'b0;
			end else begin
				next_st.spi.tx = {st.spi.tx[6:0], 1'b0};
			end
		end

		next_st.regs.signature = signature_result;

		sync_pass = sync_in & st.regs.sync_ctl[SYNC_EN_BIT];
		if (sync_pass && st.regs.sync_ctl[SYNC_NEXT_BIT]) begin
			next_st.regs.sync_ctl[SYNC_EN_BIT] = 1'b0;
		end

		// applied after the self-clear so that a host write in the same cycle wins
		if (wr_strobe) begin
			case (wr_addr)
				ADDR_DEV_INDEX:  next_st.regs.dev_index  = wr_data;
				ADDR_POWER_MODE: next_st.regs.power_mode = wr_data;
				ADDR_ENHANCE:    next_st.regs.enhance    = wr_data;
				ADDR_OUT_MODE:   next_st.regs.out_mode   = wr_data;
				ADDR_REF_SEL:    next_st.regs.ref_sel    = wr_data;
				ADDR_PAT1_LO:    next_st.regs.pat1_lo    = wr_data;
				ADDR_PAT1_HI:    next_st.regs.pat1_hi    = wr_data;
				ADDR_PAT2_LO:    next_st.regs.pat2_lo    = wr_data;
				ADDR_PAT2_HI:    next_st.regs.pat2_hi    = wr_data;
				ADDR_OVR:        next_st.regs.ovr        = wr_data;
				ADDR_OUT_ASSIGN: begin
					if (st.regs.dev_index[0]) begin
						next_st.regs.out_assign[0] = wr_data[0];
					end
					if (st.regs.dev_index[1]) begin
						next_st.regs.out_assign[1] = wr_data[0];
					end
				end
				ADDR_SYNC:       next_st.regs.sync_ctl    = wr_data;
				ADDR_RATE:       next_st.regs.rate_staged = wr_data;
				ADDR_TRANSFER: begin
					if (wr_data[TRANSFER_BIT]) begin
						next_st.regs.rate_active = st.regs.rate_staged;
					end
				end
				ADDR_PIN2:       next_st.regs.pin2 = wr_data;
				ADDR_PIN3:       next_st.regs.pin3 = wr_data;
				default:         next_st.regs = next_st.regs;
			endcase
		end

		// control decode, one cycle behind the registers
		rate_upgrade = st.regs.rate_active[RATE_EN_BIT] &&
			(st.regs.rate_active[RATE_LSB +: 3] > SPEED_GRADE_CODE);
		if (power_down_pin) begin
			eff_mode = st.regs.power_mode[PM_EXT_FUNC_BIT] ? PM_POWER_DOWN : PM_STANDBY;
		end else begin
			eff_mode = st.regs.power_mode[1:0];
		end
		if (rate_upgrade) begin
			eff_mode = PM_POWER_DOWN;
		end
		pm_bits = pm_decode(eff_mode);

		next_st.ctl.ref_span         = st.regs.ref_sel[REF_LSB +: 3];
		next_st.ctl.pattern_one      = {st.regs.pat1_hi, st.regs.pat1_lo};
		next_st.ctl.pattern_two      = {st.regs.pat2_hi, st.regs.pat2_lo};
		next_st.ctl.overrange_out_en = st.regs.ovr[OVR_EN_BIT];
		next_st.ctl.chan_a_source    = st.regs.out_assign[0];
		next_st.ctl.chan_b_source    = st.regs.out_assign[1];
		next_st.ctl.chop_en          = st.regs.enhance[CHOP_BIT];
		next_st.ctl.logic_type       = st.regs.out_mode[LOGIC_TYPE_LSB +: 2];
		next_st.ctl.datapath_clk_en  = pm_bits[2];
		next_st.ctl.datapath_reset   = pm_bits[1];
		// output disable pin only counts once software has enabled it
		next_st.ctl.data_out_en      = pm_bits[0] &
			~(st.regs.pin2[OUT_DIS_EN_BIT] & output_disable_pin);
		next_st.ctl.full_power_down  = (eff_mode == PM_POWER_DOWN);
		next_st.ctl.standby          = (eff_mode == PM_STANDBY);
		next_st.ctl.divider_sync     = sync_pass;
		next_st.ctl.rate_override_en = st.regs.rate_active[RATE_EN_BIT];
		next_st.ctl.rate_code        = st.regs.rate_active[RATE_LSB +: 3];
		next_st.ctl.sdio_pulldown_disable = st.regs.pin2[PULLDOWN_DIS_BIT];
		next_st.ctl.common_mode_generator_power_down = st.regs.pin3[CM_PD_BIT];
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			st                  <= '0;
			st.regs.dev_index   <= RST_DEV_INDEX;
			st.regs.power_mode  <= RST_POWER_MODE;
			st.regs.enhance     <= RST_ENHANCE;
			st.regs.out_mode    <= RST_OUT_MODE;
			st.regs.ref_sel     <= RST_REF_SEL;
			st.regs.pat1_lo     <= RST_PATTERN;
			st.regs.pat1_hi     <= RST_PATTERN;
			st.regs.pat2_lo     <= RST_PATTERN;
			st.regs.pat2_hi     <= RST_PATTERN;
			st.regs.signature   <= RST_SIGNATURE;
			st.regs.ovr         <= RST_OVR;
			st.regs.sync_ctl    <= RST_SYNC;
			st.regs.rate_staged <= RST_RATE;
			st.regs.rate_active <= RST_RATE;
			st.regs.pin2        <= RST_PIN;
			st.regs.pin3        <= RST_PIN;
			st.spi.sclk_prev    <= 1'b0;
			st.ctl.ref_span         <= RST_REF_SEL[2:0];
			st.ctl.overrange_out_en <= RST_OVR[0];
			st.ctl.datapath_clk_en  <= 1'b1;
			st.ctl.data_out_en      <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

endmodule : dacr_config_regs

// [tb/dacr_spi_host.sv]
// host model for the three-wire control port
// assumes sclk idles low between frames and the bench calls xfer
module dacr_spi_host (
	input  wire logic core_clk,
	input  wire logic sdio_out,
	input  wire logic sdio_oe,
	input  wire logic pd_dis,
	output logic      sclk,
	output logic      cs_n,
	output logic      sdio
);
	timeunit 1ns;
	timeprecision 1ps;
	logic h_oe;
	logic h_d;
	logic last = 1'b0;
	// released line: pull-down, or a wandering level once it is disabled
	assign sdio = h_oe ? h_d : sdio_oe ? sdio_out : pd_dis & ~last;
	always @(posedge core_clk) last <= sdio;
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		h_oe = 1'b0;
		h_d  = 1'b0;
	end
	task automatic xfer(input logic rd, input logic [12:0] a, input logic [7:0] wd,
		output logic [7:0] q);
		logic [23:0] s;
		s = {rd, 2'b00, a, wd};
		cs_n = 1'b0;
		h_oe = 1'b1;
		for (int i = 23; i >= 0; i--) begin
			if (i == 7 && rd)
				h_oe = 1'b0;
			h_d = s[i];
			repeat (3) @(negedge core_clk);
			q = {q[6:0], sdio};
			sclk = 1'b1;
			repeat (3) @(negedge core_clk);
			sclk = 1'b0;
		end
		repeat (2) @(negedge core_clk);
		cs_n = 1'b1;
		h_oe = 1'b0;
		@(negedge core_clk);
	endtask : xfer
endmodule : dacr_spi_host

// [tb/dacr_config_regs_chk.sv]
// port-level checks of the config bank control outputs
// assumes one core_clk domain with synchronous active-high reset
module dacr_config_regs_chk
	import dacr_pkg::*;
(
	input wire logic                  core_clk,
	input wire logic                  reset,
	input wire logic                  power_down_pin,
	input wire logic                  sync_in,
	input wire dacr_pkg::dacr_ctl_type ctl
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	a_reset_span: assert property ($past(reset) |-> ctl.ref_span == 3'h4 && ctl.overrange_out_en)
		else $error("span or overrange off reset value");
	a_normal_run: assert property (ctl.datapath_clk_en |-> !ctl.datapath_reset && ctl.data_out_en)
		else $error("running clocks without clean outputs");
	a_pd_mode: assert property (ctl.full_power_down |-> !ctl.datapath_clk_en && ctl.datapath_reset)
		else $error("power-down decode wrong");
	a_standby_mode: assert property (ctl.standby |-> !ctl.datapath_reset && !ctl.data_out_en)
		else $error("standby decode wrong");
	a_dig_reset: assert property (ctl.datapath_reset && !ctl.full_power_down |-> ctl.data_out_en)
		else $error("digital reset disabled outputs");
	a_pin_down: assert property (power_down_pin [*3] |-> ctl.full_power_down || ctl.standby)
		else $error("pin held but no low-power state");
	a_rate_up: assert property (ctl.rate_override_en && ctl.rate_code > SPEED_GRADE_CODE |-> ctl.full_power_down)
		else $error("rate upgrade kept chip running");
	a_sync_gate: assert property (ctl.divider_sync |-> $past(sync_in) || $past(sync_in, 2))
		else $error("divider sync without a sync pulse");
endmodule : dacr_config_regs_chk
bind dacr_config_regs dacr_config_regs_chk chk_u (.core_clk(core_clk), .reset(reset),
	.power_down_pin(power_down_pin), .sync_in(sync_in), .ctl(ctl));

// [tb/dacr_config_regs_tb.sv]
// self-checking bench for the config register bank
// assumes the host model drives the serial port at a sixth of core rate
module dacr_config_regs_tb
	import dacr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic         core_clk = 1'b0;
	logic         reset    = 1'b1;
	logic         pd_pin   = 1'b0;
	logic         sync_in  = 1'b0;
	logic [15:0]  sig      = 16'h5aa5;
	logic [7:0]   q;
	wire          sclk, cs_n, sdio, sdio_out, sdio_oe;
	dacr_ctl_type ctl;
	int           err_count = 0;
	int           checked   = 0;
	always #12.5 core_clk = ~core_clk;
	dacr_config_regs dut_u (.core_clk(core_clk), .reset(reset), .spi_sclk(sclk),
		.spi_cs_n(cs_n), .sdio_in(sdio), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
		.power_down_pin(pd_pin), .output_disable_pin(1'b0), .sync_in(sync_in),
		.signature_result(sig), .ctl(ctl));
	dacr_spi_host host_u (.core_clk(core_clk), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
		.pd_dis(ctl.sdio_pulldown_disable), .sclk(sclk), .cs_n(cs_n), .sdio(sdio));
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wr(input logic [12:0] a, input logic [7:0] d);
		host_u.xfer(1'b0, a, d, q);
	endtask : wr
	task automatic rd(input logic [12:0] a, input logic [7:0] e, input string n);
		host_u.xfer(1'b1, a, 8'h00, q);
		chk(n, {8'h00, e}, {8'h00, q});
	endtask : rd
	task automatic pulse(output logic s);
		@(negedge core_clk);
		sync_in = 1'b1;
		@(negedge core_clk);
		sync_in = 1'b0;
		s = ctl.divider_sync;
		@(negedge core_clk);
		s = s | ctl.divider_sync;
	endtask : pulse
	task automatic end_sim;
		$display("checked %0d err_count %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : end_sim
	task automatic t_reset;
		chk("ref_span", 16'h4, 16'(ctl.ref_span));
		rd(ADDR_OVR, RST_OVR, "ovr");
		rd(ADDR_SIG_LO, 8'ha5, "sig_lo");
		rd(ADDR_SIG_HI, 8'h5a, "sig_hi");
		rd(ADDR_RATE, RST_RATE, "rate");
	endtask : t_reset
	task automatic t_fields;
		for (int i = 0; i < 5; i++) begin
			wr(ADDR_REF_SEL, 8'(i));
			chk("ref_span", 16'(i), 16'(ctl.ref_span));
		end
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_OUT_MODE, 8'(i << 6));
			if (i != 1)
				chk("logic_type", 16'(i), 16'(ctl.logic_type));
		end
		wr(ADDR_ENHANCE, 8'h04);
		chk("chop", 16'h1, 16'(ctl.chop_en));
		wr(ADDR_OVR, 8'h00);
		chk("ovr_en", 16'h0, 16'(ctl.overrange_out_en));
		wr(ADDR_PAT1_LO, 8'h34);
		wr(ADDR_PAT1_HI, 8'h12);
		chk("pattern_one", 16'h1234, ctl.pattern_one);
		wr(ADDR_PAT2_HI, 8'h56);
		wr(ADDR_PAT2_LO, 8'h78);
		chk("pattern_two", 16'h5678, ctl.pattern_two);
		wr(ADDR_PIN2, 8'h01);
		chk("pulldown_dis", 16'h1, 16'(ctl.sdio_pulldown_disable));
		wr(ADDR_PIN2, 8'h00);
		chk("pulldown_on", 16'h0, 16'(ctl.sdio_pulldown_disable));
		wr(ADDR_PIN3, 8'h08);
		chk("cm_gen_pd", 16'h1, 16'(ctl.common_mode_generator_power_down));
		// both channels selected: one write reaches both
		wr(ADDR_OUT_ASSIGN, 8'h01);
		chk("assign_ab", 16'h3, 16'({ctl.chan_b_source, ctl.chan_a_source}));
		wr(ADDR_DEV_INDEX, 8'h02);
		wr(ADDR_OUT_ASSIGN, 8'h00);
		chk("assign_b", 16'h1, 16'({ctl.chan_b_source, ctl.chan_a_source}));
		rd(ADDR_OUT_ASSIGN, 8'h00, "assign_rd_b");
		wr(ADDR_DEV_INDEX, 8'h01);
		rd(ADDR_OUT_ASSIGN, 8'h01, "assign_rd_a");
		wr(ADDR_SIG_LO, 8'h00);
		rd(ADDR_SIG_LO, 8'ha5, "sig_ro");
		rd(13'h0003, 8'h00, "unmapped");
	endtask : t_fields
	task automatic t_power;
		logic [2:0] ex [4] = '{3'b101, 3'b010, 3'b000, 3'b011};
		logic [2:0] got;
		wr(ADDR_DEV_INDEX, 8'h03);
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_POWER_MODE, 8'(i));
			got = {ctl.datapath_clk_en, ctl.datapath_reset, ctl.data_out_en};
			chk("mode", 16'(ex[i]), 16'(got));
		end
		wr(ADDR_POWER_MODE, 8'h20);
		pd_pin = 1'b1;
		repeat (3) @(negedge core_clk);
		chk("pin_pd", 16'h2, 16'({ctl.full_power_down, ctl.standby}));
		wr(ADDR_POWER_MODE, 8'h00);
		chk("pin_sb", 16'h1, 16'({ctl.full_power_down, ctl.standby}));
		pd_pin = 1'b0;
	endtask : t_power
	task automatic t_rate;
		wr(ADDR_RATE, 8'({5'h08, SPEED_GRADE_CODE}));
		chk("staged", 16'h0, 16'({ctl.rate_override_en, ctl.rate_code}));
		wr(ADDR_TRANSFER, 8'h01);
		chk("rate_on", 16'({1'b1, SPEED_GRADE_CODE}), 16'({ctl.rate_override_en, ctl.rate_code}));
		chk("rate_pd", 16'h0, 16'(ctl.full_power_down));
		wr(ADDR_RATE, 8'({5'h08, SPEED_GRADE_CODE + 3'h1}));
		wr(ADDR_TRANSFER, 8'h01);
		chk("rate_up", 16'h1, 16'(ctl.full_power_down));
		wr(ADDR_RATE, 8'h00);
		wr(ADDR_TRANSFER, 8'h01);
	endtask : t_rate
	task automatic t_sync;
		logic s;
		pulse(s);
		chk("sync_off", 16'h0, 16'(s));
		wr(ADDR_SYNC, 8'h02);
		pulse(s);
		chk("sync_on", 16'h1, 16'(s));
		pulse(s);
		chk("sync_cont", 16'h1, 16'(s));
		wr(ADDR_SYNC, 8'h06);
		pulse(s);
		chk("sync_first", 16'h1, 16'(s));
		pulse(s);
		chk("sync_later", 16'h0, 16'(s));
		rd(ADDR_SYNC, 8'h04, "sync_clear");
	endtask : t_sync
	initial begin
		repeat (8) @(negedge core_clk);
		reset = 1'b0;
		@(negedge core_clk);
		t_reset();
		t_fields();
		t_power();
		t_rate();
		t_sync();
		// mid-run reset must bring back the reset values
		reset = 1'b1;
		repeat (2) @(negedge core_clk);
		reset = 1'b0;
		@(negedge core_clk);
		chk("ovr_rst", 16'h1, 16'(ctl.overrange_out_en));
		rd(ADDR_SYNC, RST_SYNC, "sync_rst");
		end_sim();
	end
	// about fifty frames of 150 cycles each; a hang runs far past this
	initial begin
		#1000000;
		err_count++;
		end_sim();
	end
endmodule : dacr_config_regs_tb
